// >>> src/mlb_timing_pkg.sv
// constants for the multilayer bus access timing and byte-order block
package mlb_timing_pkg;
  // access targets
  localparam logic [2:0] TGT_FLASH = 3'h0;
  localparam logic [2:0] TGT_SRAM = 3'h1;
  localparam logic [2:0] TGT_PERIPH = 3'h2;
  localparam logic [2:0] TGT_FLASH_IF = 3'h3;
  localparam logic [2:0] TGT_ETH_DMA = 3'h4;
  localparam logic [2:0] TGT_ETH_MAC = 3'h5;
  // on-chip memory latencies in core cycles
  localparam logic [3:0] LAT_FLASH_HIT = 4'h1;
  localparam logic [3:0] LAT_FLASH_MISS = 4'h4;
  localparam logic [3:0] LAT_SRAM_LOW = 4'h1;
  localparam logic [3:0] LAT_SRAM_HI_RD = 4'h2;
  localparam logic [3:0] LAT_SRAM_HI_WR = 4'h3;
  localparam logic [2:0] SRAM_FIRST_SLOW_PAGE = 3'h4;
  localparam logic [3:0] LAT_ERROR = 4'h1;
  // bus, peripheral and return phase lengths
  localparam logic [3:0] BUS_ORDINARY = 4'h1;
  localparam logic [3:0] BUS_DMA_WR = 4'h3;
  localparam logic [3:0] BUS_DMA_RD = 4'h4;
  localparam logic [3:0] BUS_MAC_WR = 4'h9;
  localparam logic [3:0] BUS_MAC_RD = 4'hC;
  localparam logic [3:0] PER_ORDINARY = 4'h2;
  localparam logic [3:0] PER_FLASH_IF = 4'h3;
  localparam logic [3:0] RET_BASE = 4'h2;
  // core-to-bus ratio codes
  localparam logic [1:0] CB_RATIO_1 = 2'h0;
  localparam logic [1:0] CB_RATIO_2 = 2'h1;
  localparam logic [1:0] CB_RATIO_4 = 2'h2;
  localparam logic [1:0] CB_RATIO_8 = 2'h3;
  // bus-to-peripheral ratio codes
  localparam logic BP_RATIO_1 = 1'h0;
  localparam logic BP_RATIO_2 = 1'h1;
  // byte order: one bit per area, 1 is big-endian
  localparam int AREAS = 8;
  localparam logic [7:0] ENDIAN_RST = 8'hFF;
endpackage : mlb_timing_pkg

// >>> src/mlb_timing.sv
// access timing engine and external byte-lane steering
// What this block does
// RULE_01 - flash reads take 1 core cycle on a cache hit and 4 on a miss; sram pages 0-3 take 1, pages 4-7 take 2 to read and 3 to write.
// RULE_02 - the core, internal bus and peripheral bus layers each advance on their own clock, here core cycles and enable pulses.
// RULE_03 - an ordinary peripheral write takes (2+n) core, (1+m) bus and 2 peripheral cycles.
// RULE_04 - an ordinary peripheral read takes the write time plus a (2+l) core-cycle return.
// RULE_05 - flash interface module accesses spend 3 peripheral cycles instead of 2.
// RULE_06 - ethernet dma controller accesses skip the peripheral bus: 3 bus cycles to write, 4 plus return to read.
// RULE_07 - ethernet mac controller accesses take 9 bus cycles to write, 12 plus return to read.
// RULE_08 - the waits n and m follow the divider phase and stay below the clock ratio.
// RULE_09 - each area has a byte-order setting that is only taken while that area is not accessed.
// RULE_10 - the byte-order setting of area 0 has no effect.
// RULE_11 - area 0 always works big-endian.
// RULE_12 - big-endian puts address 0 on the upper lane strobe, little-endian on the lower.
`timescale 1ns/1ps
module mlb_timing (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // clock ratios
  input wire logic [1:0] i_core_bus_ratio,
  input wire logic i_bus_per_ratio,
  // on-chip access request
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [2:0] i_target,
  input wire logic i_cache_hit,
  input wire logic [2:0] i_sram_page,
  // on-chip access answer
  output logic o_busy,
  output logic o_done,
  output logic o_error,
  // external area write request
  input wire logic i_ext_req,
  input wire logic [2:0] i_ext_area,
  input wire logic i_ext_addr0,
  input wire logic i_ext_size16,
  input wire logic [15:0] i_ext_wdata,
  input wire logic [7:0] i_area_endian_cfg,
  // external bus drive
  output logic o_ext_wr,
  output logic o_upper_byte_write_strobe,
  output logic o_lower_byte_write_strobe,
  output logic [15:0] o_ext_wdata,
  output logic o_ext_big_endian
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MEM = 3'b001,
    ST_CORE = 3'b010,
    ST_BUS = 3'b011,
    ST_PERI = 3'b100,
    ST_RET = 3'b101
  } state_e;

  typedef struct packed {
    state_e st;
    logic [3:0] cnt;
    logic [2:0] bdiv;
    logic pdiv;
    logic wr;
    logic [2:0] tgt;
    logic busy;
    logic done;
    logic err;
    logic [7:0] endian;
    logic ext_wr;
    logic up_stb;
    logic lo_stb;
    logic [15:0] wdata;
    logic big;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic bus_en;
  logic per_en;
  logic ret_l;

  // divider mask for the core-to-bus ratio
  function automatic logic [2:0] div_mask(input logic [1:0] r);
    case (r)
      mlb_timing_pkg::CB_RATIO_1: div_mask = 3'h0;
      mlb_timing_pkg::CB_RATIO_2: div_mask = 3'h1;
      mlb_timing_pkg::CB_RATIO_4: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction : div_mask

  // effective byte order of an area
  function automatic logic area_big(input logic [7:0] e, input logic [2:0] a);
    // RULE_10 area 0 setting ignored
    // RULE_11 area 0 forced big
    area_big = (a == 3'h0) ? 1'b1 : e[a];
  endfunction : area_big

  // bus and peripheral enable pulses
  // RULE_02 per-layer clock enables
  assign bus_en = ((s_r.bdiv & div_mask(i_core_bus_ratio)) == 3'h0);
  assign per_en = bus_en && ((i_bus_per_ratio == mlb_timing_pkg::BP_RATIO_1) || !s_r.pdiv);
  // return wait l: 1 at 8:1, phase dependent at 4:1, else 0
  assign ret_l = (i_core_bus_ratio == mlb_timing_pkg::CB_RATIO_8) ||
                 ((i_core_bus_ratio == mlb_timing_pkg::CB_RATIO_4) && s_r.bdiv[0]);

  // next-state logic
  always_comb begin
    logic [3:0] lat;
    logic phase_end;
    lat = mlb_timing_pkg::LAT_ERROR;
    phase_end = 1'b0;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.ext_wr = 1'b0;
    // RULE_08 free-running dividers set n and m
    s_nxt.bdiv = s_r.bdiv + 3'h1;
    if (bus_en) begin
      s_nxt.pdiv = ~s_r.pdiv;
    end
    case (s_r.st)
      ST_IDLE: begin
        if (i_req) begin
          s_nxt.wr = i_write;
          s_nxt.tgt = i_target;
          s_nxt.busy = 1'b1;
          case (i_target)
            // RULE_01 memory latency select
            mlb_timing_pkg::TGT_FLASH: begin
              lat = i_cache_hit ? mlb_timing_pkg::LAT_FLASH_HIT
                                : mlb_timing_pkg::LAT_FLASH_MISS;
              if (i_write) begin
                lat = mlb_timing_pkg::LAT_ERROR;
                s_nxt.err = 1'b1;
              end
            end
            mlb_timing_pkg::TGT_SRAM: begin
              if (i_sram_page < mlb_timing_pkg::SRAM_FIRST_SLOW_PAGE) begin
                lat = mlb_timing_pkg::LAT_SRAM_LOW;
              end else begin
                lat = i_write ? mlb_timing_pkg::LAT_SRAM_HI_WR
                              : mlb_timing_pkg::LAT_SRAM_HI_RD;
              end
            end
            mlb_timing_pkg::TGT_PERIPH, mlb_timing_pkg::TGT_FLASH_IF,
            mlb_timing_pkg::TGT_ETH_DMA, mlb_timing_pkg::TGT_ETH_MAC: begin
              lat = 4'h0;
              s_nxt.st = ST_CORE;
            end
            default: begin
              s_nxt.err = 1'b1;
            end
          endcase
          if (lat == 4'h1) begin
            s_nxt.done = 1'b1;
            s_nxt.busy = 1'b0;
          end else if (lat != 4'h0) begin
            s_nxt.st = ST_MEM;
            s_nxt.cnt = lat - 4'h1;
          end
        end
      end
      ST_MEM: begin
        if (s_r.cnt == 4'h1) begin
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      // RULE_03 core part waits n for a bus edge
      ST_CORE: begin
        if (bus_en) begin
          s_nxt.st = ST_BUS;
          case (s_r.tgt)
            // RULE_06 dma bus length
            mlb_timing_pkg::TGT_ETH_DMA:
              s_nxt.cnt = s_r.wr ? mlb_timing_pkg::BUS_DMA_WR : mlb_timing_pkg::BUS_DMA_RD;
            // RULE_07 mac bus length
            mlb_timing_pkg::TGT_ETH_MAC:
              s_nxt.cnt = s_r.wr ? mlb_timing_pkg::BUS_MAC_WR : mlb_timing_pkg::BUS_MAC_RD;
            default:
              s_nxt.cnt = mlb_timing_pkg::BUS_ORDINARY;
          endcase
        end
      end
      ST_BUS: begin
        if (bus_en) begin
          if (s_r.cnt != 4'h1) begin
            s_nxt.cnt = s_r.cnt - 4'h1;
          end else if ((s_r.tgt == mlb_timing_pkg::TGT_ETH_DMA) ||
                       (s_r.tgt == mlb_timing_pkg::TGT_ETH_MAC)) begin
            phase_end = 1'b1;
          end else if (per_en) begin
            // RULE_05 flash interface peripheral length
            s_nxt.st = ST_PERI;
            s_nxt.cnt = (s_r.tgt == mlb_timing_pkg::TGT_FLASH_IF) ?
                        mlb_timing_pkg::PER_FLASH_IF : mlb_timing_pkg::PER_ORDINARY;
          end
        end
      end
      ST_PERI: begin
        if (per_en) begin
          if (s_r.cnt == 4'h1) begin
            phase_end = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 4'h1;
          end
        end
      end
      ST_RET: begin
        if (s_r.cnt == 4'h1) begin
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
    // RULE_04 reads add the return path
    if (phase_end) begin
      if (s_r.wr) begin
        s_nxt.done = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.st = ST_IDLE;
      end else begin
        s_nxt.st = ST_RET;
        s_nxt.cnt = mlb_timing_pkg::RET_BASE + {3'h0, ret_l};
      end
    end
    // RULE_09 byte order held while its area is accessed
    for (int i = 0; i < mlb_timing_pkg::AREAS; i++) begin
      if (!(i_ext_req && (i_ext_area == i[2:0]))) begin
        s_nxt.endian[i] = i_area_endian_cfg[i];
      end
    end
    // RULE_12 lane and strobe steering
    if (i_ext_req) begin
      s_nxt.ext_wr = 1'b1;
      s_nxt.big = area_big(s_r.endian, i_ext_area);
      if (i_ext_size16) begin
        s_nxt.up_stb = 1'b1;
        s_nxt.lo_stb = 1'b1;
        s_nxt.wdata = i_ext_wdata;
      end else begin
        s_nxt.up_stb = (i_ext_addr0 == 1'b0) == s_nxt.big;
        s_nxt.lo_stb = !s_nxt.up_stb;
        s_nxt.wdata = {i_ext_wdata[7:0], i_ext_wdata[7:0]};
      end
    end else begin
      s_nxt.up_stb = 1'b0;
      s_nxt.lo_stb = 1'b0;
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_r <= '0;
      s_r.endian <= mlb_timing_pkg::ENDIAN_RST;
      s_r.big <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign o_busy = s_r.busy;
  assign o_done = s_r.done;
  assign o_error = s_r.err;
  assign o_ext_wr = s_r.ext_wr;
  assign o_upper_byte_write_strobe = s_r.up_stb;
  assign o_lower_byte_write_strobe = s_r.lo_stb;
  assign o_ext_wdata = s_r.wdata;
  assign o_ext_big_endian = s_r.big;

  // checks
  logic ratio_11;
  assign ratio_11 = (i_core_bus_ratio == mlb_timing_pkg::CB_RATIO_1) && !i_bus_per_ratio;
  sequence s_take(logic [2:0] t, logic w);
    !o_busy && i_req && (i_target == t) && (i_write == w) && ratio_11;
  endsequence
  sequence s_pulse;
    o_done ##1 !o_done;
  endsequence

  a_flash_hit_lat: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_01
    !o_busy && i_req && !i_write && (i_target == mlb_timing_pkg::TGT_FLASH) && i_cache_hit
    |-> ##1 s_pulse) else $error("flash hit latency wrong");
  a_flash_miss_lat: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_01
    !o_busy && i_req && !i_write && (i_target == mlb_timing_pkg::TGT_FLASH) && !i_cache_hit
    |-> ##1 !o_done [*3] ##1 o_done) else $error("flash miss latency wrong");
  a_sram_slow_wr: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_01
    !o_busy && i_req && i_write && (i_target == mlb_timing_pkg::TGT_SRAM) && i_sram_page[2]
    |-> ##1 !o_done [*2] ##1 o_done) else $error("slow sram write latency wrong");
  a_per_wr_time: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_03
    s_take(mlb_timing_pkg::TGT_PERIPH, 1'b1) |-> ##1 !o_done [*4] ##1 s_pulse)
    else $error("peripheral write time wrong");
  a_per_rd_time: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_04
    s_take(mlb_timing_pkg::TGT_PERIPH, 1'b0) |-> ##7 s_pulse) else $error("peripheral read time wrong");
  a_flash_if_wr: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_05
    s_take(mlb_timing_pkg::TGT_FLASH_IF, 1'b1) |-> ##1 !o_done [*5] ##1 o_done)
    else $error("flash interface write time wrong");
  a_dma_wr_time: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_06
    s_take(mlb_timing_pkg::TGT_ETH_DMA, 1'b1) |-> ##5 s_pulse) else $error("dma write time wrong");
  a_mac_rd_time: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_07
    s_take(mlb_timing_pkg::TGT_ETH_MAC, 1'b0) |-> ##16 o_done) else $error("mac read time wrong");
  a_wait_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_08
    !o_busy && i_req && (i_target == mlb_timing_pkg::TGT_PERIPH) && i_write
    && (i_core_bus_ratio == mlb_timing_pkg::CB_RATIO_8) && !i_bus_per_ratio
    |-> ##[26:33] o_done) else $error("wait exceeds ratio bound");
  a_per_in_bus: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_02
    per_en |-> bus_en) else $error("peripheral edge off bus edge");
  a_cfg_frozen: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_09
    i_ext_req |=> s_r.endian[$past(i_ext_area)] == $past(s_r.endian[i_ext_area]))
    else $error("byte order changed during access");
  a_area0_big: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_11
    i_ext_req && (i_ext_area == 3'h0) && !i_ext_size16 && !i_ext_addr0
    |=> o_ext_big_endian && o_upper_byte_write_strobe && !o_lower_byte_write_strobe)
    else $error("area 0 not big-endian");
  a_little_lane: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_12
    i_ext_req && !i_ext_size16 && !i_ext_addr0 && !area_big(s_r.endian, i_ext_area)
    |=> o_lower_byte_write_strobe && !o_upper_byte_write_strobe)
    else $error("little-endian lane wrong");
endmodule : mlb_timing

// >>> bench/core_meter.sv
// core-side latency meter standing where the cpu master watches each access
`timescale 1ns/1ps
module core_meter (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // observed handshake
  input wire logic i_req,
  input wire logic i_busy,
  input wire logic i_done,
  // measured core cycles of the last access
  output logic [7:0] o_lat
);
  logic [7:0] cnt_r;
  // the taking edge counts as the first core cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_r <= 8'h00;
      o_lat <= 8'h00;
    end else begin
      if (i_done && cnt_r != 8'h00) begin
        o_lat <= cnt_r;
      end
      if (i_req && !i_busy) begin
        cnt_r <= 8'h01;
      end else if (i_done) begin
        cnt_r <= 8'h00;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule : core_meter

// >>> bench/multilayer_bus_access_timing_test.sv
// self-checking bench for access timing and byte-lane steering
`timescale 1ns/1ps
module multilayer_bus_access_timing_test;
  logic i_clk, i_sys_rst, i_bus_per_ratio, i_req, i_write, i_cache_hit;
  logic [1:0] i_core_bus_ratio;
  logic [2:0] i_target, i_sram_page, i_ext_area;
  logic i_ext_req, i_ext_addr0, i_ext_size16;
  logic [15:0] i_ext_wdata, o_ext_wdata;
  logic [7:0] i_area_endian_cfg, lat;
  logic o_busy, o_done, o_error, o_ext_wr, o_up, o_lo, o_big;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  mlb_timing mlb_timing_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_core_bus_ratio(i_core_bus_ratio), .i_bus_per_ratio(i_bus_per_ratio),
    .i_req(i_req), .i_write(i_write), .i_target(i_target), .i_cache_hit(i_cache_hit),
    .i_sram_page(i_sram_page), .o_busy(o_busy), .o_done(o_done), .o_error(o_error),
    .i_ext_req(i_ext_req), .i_ext_area(i_ext_area), .i_ext_addr0(i_ext_addr0),
    .i_ext_size16(i_ext_size16), .i_ext_wdata(i_ext_wdata),
    .i_area_endian_cfg(i_area_endian_cfg), .o_ext_wr(o_ext_wr),
    .o_upper_byte_write_strobe(o_up), .o_lower_byte_write_strobe(o_lo),
    .o_ext_wdata(o_ext_wdata), .o_ext_big_endian(o_big));
  core_meter core_meter_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
    .i_busy(o_busy), .i_done(o_done), .o_lat(lat));
  // clock, 10 ns period
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // one on-chip access, latency judged against lo..hi core cycles
  task automatic acc(input logic wr, input logic [2:0] tg, input logic hit,
    input logic [2:0] pg, input logic [7:0] lo, input logic [7:0] hi, input logic err);
    logic e;
    logic seen;
    e = 1'b0;
    seen = 1'b0;
    @(posedge i_clk);
    i_req <= 1'b1;
    i_write <= wr;
    i_target <= tg;
    i_cache_hit <= hit;
    i_sram_page <= pg;
    @(posedge i_clk);
    i_req <= 1'b0;
    for (int k = 0; k < 100; k++) begin
      @(posedge i_clk);
      e = o_error;
      if (o_done === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    #1;
    chk({15'h0000, seen}, 16'h0001);
    chk({15'h0000, e}, {15'h0000, err});
    cmp_count++;
    if (!((lat >= lo) === 1'b1 && (lat <= hi) === 1'b1)) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, lat, lo);
    end
  endtask : acc
  task automatic ratio(input logic [1:0] cb, input logic bp);
    @(posedge i_clk);
    i_core_bus_ratio <= cb;
    i_bus_per_ratio <= bp;
  endtask : ratio
  // one external write after pre idle cycles with the given byte-order setting
  task automatic ext(input logic [2:0] ar, input logic a0, input logic s16,
    input logic [7:0] cfg, input int pre, input logic up, input logic lo, input logic big);
    logic [15:0] d;
    d = s16 ? 16'hBEEF : 16'h12A5;
    @(posedge i_clk);
    i_area_endian_cfg <= cfg;
    repeat (pre) @(posedge i_clk);
    i_ext_req <= 1'b1;
    i_ext_area <= ar;
    i_ext_addr0 <= a0;
    i_ext_size16 <= s16;
    i_ext_wdata <= d;
    @(posedge i_clk);
    i_ext_req <= 1'b0;
    #1;
    chk({12'h000, o_ext_wr, o_up, o_lo, o_big}, {12'h001, up, lo, big});
    chk(o_ext_wdata, s16 ? d : {d[7:0], d[7:0]});
  endtask : ext
  // timeout guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  // main sequence
  initial begin
    {i_req, i_write, i_cache_hit, i_bus_per_ratio, i_ext_req} = 5'h00;
    {i_ext_addr0, i_ext_size16, i_core_bus_ratio} = 4'h0;
    {i_target, i_sram_page, i_ext_area} = 9'h000;
    i_ext_wdata = 16'h0000;
    i_area_endian_cfg = 8'hFF;
    i_sys_rst = 1'b1;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({o_busy, o_done, o_ext_wr, o_big, o_ext_wdata[11:0]}, 16'h1000);
    acc(1'b0, 3'h0, 1'b1, 3'h0, 8'h01, 8'h01, 1'b0);
    acc(1'b0, 3'h0, 1'b0, 3'h0, 8'h04, 8'h04, 1'b0);
    acc(1'b1, 3'h0, 1'b1, 3'h0, 8'h01, 8'h01, 1'b1);
    acc(1'b0, 3'h1, 1'b0, 3'h3, 8'h01, 8'h01, 1'b0);
    acc(1'b1, 3'h1, 1'b0, 3'h3, 8'h01, 8'h01, 1'b0);
    acc(1'b0, 3'h1, 1'b0, 3'h4, 8'h02, 8'h02, 1'b0);
    acc(1'b1, 3'h1, 1'b0, 3'h7, 8'h03, 8'h03, 1'b0);
    acc(1'b1, 3'h2, 1'b0, 3'h0, 8'h05, 8'h05, 1'b0);
    acc(1'b0, 3'h2, 1'b0, 3'h0, 8'h07, 8'h07, 1'b0);
    acc(1'b1, 3'h3, 1'b0, 3'h0, 8'h06, 8'h06, 1'b0);
    acc(1'b0, 3'h3, 1'b0, 3'h0, 8'h08, 8'h08, 1'b0);
    acc(1'b1, 3'h4, 1'b0, 3'h0, 8'h05, 8'h05, 1'b0);
    acc(1'b0, 3'h4, 1'b0, 3'h0, 8'h08, 8'h08, 1'b0);
    acc(1'b1, 3'h5, 1'b0, 3'h0, 8'h0B, 8'h0B, 1'b0);
    acc(1'b0, 3'h5, 1'b0, 3'h0, 8'h10, 8'h10, 1'b0);
    acc(1'b0, 3'h6, 1'b0, 3'h0, 8'h01, 8'h01, 1'b1);
    ratio(2'h1, 1'b0);
    acc(1'b1, 3'h2, 1'b0, 3'h0, 8'h08, 8'h09, 1'b0);
    ratio(2'h3, 1'b0);
    acc(1'b0, 3'h4, 1'b0, 3'h0, 8'h25, 8'h2C, 1'b0);
    acc(1'b1, 3'h2, 1'b0, 3'h0, 8'h1A, 8'h21, 1'b0);
    ratio(2'h0, 1'b1);
    acc(1'b1, 3'h2, 1'b0, 3'h0, 8'h07, 8'h08, 1'b0);
    ext(3'h2, 1'b0, 1'b0, 8'hFB, 2, 1'b0, 1'b1, 1'b0);
    ext(3'h2, 1'b1, 1'b0, 8'hFB, 2, 1'b1, 1'b0, 1'b0);
    ext(3'h2, 1'b0, 1'b0, 8'hFF, 2, 1'b1, 1'b0, 1'b1);
    ext(3'h2, 1'b1, 1'b0, 8'hFF, 2, 1'b0, 1'b1, 1'b1);
    ext(3'h0, 1'b0, 1'b0, 8'hFE, 2, 1'b1, 1'b0, 1'b1);
    ext(3'h3, 1'b0, 1'b1, 8'hF7, 2, 1'b1, 1'b1, 1'b0);
    ext(3'h5, 1'b0, 1'b0, 8'hD7, 0, 1'b1, 1'b0, 1'b1);
    ext(3'h5, 1'b0, 1'b0, 8'hD7, 2, 1'b0, 1'b1, 1'b0);
    results();
  end
endmodule : multilayer_bus_access_timing_test
